// [rtl/tss_pkg.sv]
// shared constants and types for the touch scan sequencer
package tss_pkg;
  localparam int CLK_PERIOD_NS       = 10;
  localparam int UPDATE_DELAY_NS     = 250000;
  localparam int UPDATE_DELAY_CYCLES = (UPDATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCAN_WINDOW_CYCLES  = 64;
  localparam int COUNT_W             = 16;
  localparam int MOD_W               = 16;
  localparam int PSC_W               = 3;
  localparam int DELAY_W             = 16;

  localparam logic CLKSRC_SYS = 1'b0;
  localparam logic CLKSRC_EXT = 1'b1;

  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [MOD_W-1:0]   PERIOD_RESET = 16'h0000;

  typedef enum logic [1:0] {
    TSS_IDLE   = 2'b00,
    TSS_BURST  = 2'b01,
    TSS_SINGLE = 2'b10
  } tss_seq_t;
endpackage

// [rtl/tss_delay_timer.sv]
// one-shot delay counter: done pulses DELAY cycles after start
`timescale 1ns/1ns
module tss_delay_timer #(
  parameter int CNT_W = 16,
  parameter int DELAY = 25000
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // control
  input  wire logic start,
  input  wire logic abort,
  // status
  output logic      busy,
  output logic      done
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_busy;
  logic             next_done;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(DELAY - 1);

  generate
    if (DELAY < 1 || DELAY > (1 << CNT_W)) begin : g_bad_delay
      $error("delay does not fit the counter width");
    end
  endgenerate

  always_comb begin
    next_count = count;
    next_busy  = busy;
    next_done  = 1'b0;
    if (abort) begin
      next_busy  = 1'b0;
      next_count = '0;
    end else if (start) begin
      // a new start restarts the wait from zero
      next_busy  = 1'b1;
      next_count = '0;
    end else if (busy) begin
      if (count == LAST) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      busy  <= next_busy;
      done  <= next_done;
    end
  end
endmodule

// [rtl/tss_scan_sequencer.sv]
// touch scan sequencer: scan timing, delayed result update, flags and wakeup
`timescale 1ns/1ns

// What this block does
// - auto scan period from source, prescaler, modulo
// - auto scans repeat for one prescaled reference cycle
// - counters keep the last completed scan result
// - counters update a fixed delay after end-of-scan
// - end-of-scan interrupt rises with the flag
// - delayed update in auto and software modes
// - out-of-range flag only after counters update
// - software trigger starts a single scan when auto scan is off
// - after overrun scanning stops, results not updated
// - overrun visible as flag and interrupt
// - low-leakage stop wakes via wakeup interrupt at auto scan end when the count is above wakeup_threshold
// - low-leakage auto scan count captured for software
// - wait and low-power stop wake each scan end
module tss_scan_sequencer
  import tss_pkg::*;
#(
  parameter int SCAN_CYCLES  = tss_pkg::SCAN_WINDOW_CYCLES,
  parameter int UPDATE_DELAY = tss_pkg::UPDATE_DELAY_CYCLES
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // pins
  input  wire logic                        ext_ref_clk_pin,
  input  wire logic                        electrode_osc_pin,
  // configuration
  input  wire logic                        unit_enable,
  input  wire logic                        auto_scan_enable,
  input  wire logic                        scan_clock_source_select,
  input  wire logic [tss_pkg::PSC_W-1:0]   scan_prescaler,
  input  wire logic [tss_pkg::MOD_W-1:0]   scan_period_modulo,
  input  wire logic [tss_pkg::COUNT_W-1:0] range_low,
  input  wire logic [tss_pkg::COUNT_W-1:0] range_high,
  input  wire logic [tss_pkg::COUNT_W-1:0] wakeup_threshold,
  input  wire logic                        eos_irq_enable,
  input  wire logic                        oor_irq_enable,
  input  wire logic                        overrun_irq_enable,
  // software strobes
  input  wire logic                        software_scan_trigger,
  input  wire logic                        eos_flag_clear,
  input  wire logic                        oor_flag_clear,
  input  wire logic                        overrun_flag_clear,
  // power modes
  input  wire logic                        low_leakage_stop,
  input  wire logic                        very_low_leakage_stop,
  input  wire logic                        very_low_power_stop,
  input  wire logic                        wait_mode,
  // results and flags
  output logic [tss_pkg::COUNT_W-1:0]      result_count,
  output logic [tss_pkg::COUNT_W-1:0]      wakeup_count_value,
  output logic                             end_of_scan_flag,
  output logic                             out_of_range_flag,
  output logic                             overrun_flag,
  output logic                             scan_busy,
  // interrupts and wakeup
  output logic                             end_of_scan_irq,
  output logic                             out_of_range_irq,
  output logic                             overrun_irq,
  output logic                             low_leakage_wakeup_interrupt,
  output logic                             system_wakeup
);
  localparam int WIN_W  = $clog2(SCAN_CYCLES);
  localparam int PRE_CW = (1 << PSC_W) - 1;
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(SCAN_CYCLES - 1);

  generate
    if (SCAN_CYCLES < 2 || (1 << WIN_W) != SCAN_CYCLES) begin : g_bad_win
      $error("scan window must be a power of two, at least 2");
    end
  endgenerate

  // two-flop synchronisers, third stage only for edge detection
  logic [2:0] ext_sync;
  logic [2:0] osc_sync;
  logic       ext_edge;
  logic       osc_edge;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_sync <= 3'h0;
      osc_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_ref_clk_pin};
      osc_sync <= {osc_sync[1:0], electrode_osc_pin};
    end
  end

  assign ext_edge = ext_sync[1] & ~ext_sync[2];
  assign osc_edge = osc_sync[1] & ~osc_sync[2];

  // sequencer state
  tss_seq_t            seq;
  tss_seq_t            next_seq;
  logic [PRE_CW-1:0]   presc_cnt;
  logic [PRE_CW-1:0]   next_presc_cnt;
  logic [MOD_W-1:0]    period_cnt;
  logic [MOD_W-1:0]    next_period_cnt;
  logic [WIN_W-1:0]    win_cnt;
  logic [WIN_W-1:0]    next_win_cnt;
  logic [COUNT_W-1:0]  edge_cnt;
  logic [COUNT_W-1:0]  next_edge_cnt;
  logic [COUNT_W-1:0]  last_result;
  logic [COUNT_W-1:0]  next_last_result;
  logic [COUNT_W-1:0]  snap;
  logic [COUNT_W-1:0]  next_snap;
  logic [COUNT_W-1:0]  next_result_count;
  logic [COUNT_W-1:0]  next_wakeup_count_value;
  logic                oor_pend;
  logic                next_oor_pend;
  logic                next_eos_flag;
  logic                next_oor_flag;
  logic                next_ovr_flag;
  logic                next_ll_wake;
  logic                next_sys_wake;

  // combinational helpers
  logic              src_tick;
  logic              presc_tick;
  logic              period_start;
  logic              eos;
  logic              ovr_event;
  logic              low_leak;
  logic [PRE_CW-1:0] presc_mask;
  logic              upd_busy;
  logic              upd_done;

  tss_delay_timer #(
    .CNT_W (DELAY_W),
    .DELAY (UPDATE_DELAY)
  ) u_update_delay (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (eos),
    .abort   (~unit_enable),
    .busy    (upd_busy),
    .done    (upd_done)
  );

  always_comb begin
    next_seq                = seq;
    next_presc_cnt          = presc_cnt;
    next_period_cnt         = period_cnt;
    next_win_cnt            = win_cnt;
    next_edge_cnt           = edge_cnt;
    next_last_result        = last_result;
    next_snap               = snap;
    next_result_count       = result_count;
    next_wakeup_count_value = wakeup_count_value;
    next_oor_pend           = 1'b0;
    next_ll_wake            = 1'b0;
    next_sys_wake           = 1'b0;
    src_tick                = (scan_clock_source_select == CLKSRC_EXT) ? ext_edge : 1'b1;
    presc_mask              = PRE_CW'((1 << scan_prescaler) - 1);
    presc_tick              = 1'b0;
    period_start            = 1'b0;
    eos                     = 1'b0;
    ovr_event               = 1'b0;
    low_leak                = low_leakage_stop | very_low_leakage_stop;

    if (!unit_enable) begin
      // disabling the unit is the recovery path after overrun
      next_seq        = TSS_IDLE;
      next_presc_cnt  = '0;
      next_period_cnt = PERIOD_RESET;
      next_win_cnt    = '0;
      next_edge_cnt   = COUNT_RESET;
    end else begin
      if (src_tick) begin
        next_presc_cnt = presc_cnt + PRE_CW'(1);
        presc_tick     = (presc_cnt & presc_mask) == presc_mask;
      end
      if (presc_tick && auto_scan_enable) begin
        if (period_cnt >= scan_period_modulo) begin
          next_period_cnt = PERIOD_RESET;
          period_start    = 1'b1;
        end else begin
          next_period_cnt = period_cnt + MOD_W'(1);
        end
      end

      // scan window counting shared by both scan modes
      if (seq != TSS_IDLE) begin
        next_edge_cnt = edge_cnt + COUNT_W'(osc_edge);
        next_win_cnt  = win_cnt + WIN_W'(1);
        if (win_cnt == WIN_LAST) begin
          next_last_result = edge_cnt + COUNT_W'(osc_edge);
          next_edge_cnt    = COUNT_RESET;
        end
      end

      ovr_event = (period_start && (seq != TSS_IDLE || upd_busy))
                  || (software_scan_trigger && seq != TSS_IDLE);

      unique case (seq)
        TSS_IDLE: begin
          next_win_cnt  = '0;
          next_edge_cnt = COUNT_RESET;
          if (!overrun_flag && period_start && !ovr_event) begin
            next_seq = TSS_BURST;
          end else if (!overrun_flag && software_scan_trigger && !auto_scan_enable) begin
            next_seq = TSS_SINGLE;
          end
        end
        TSS_BURST: begin
          // scans restart until the next prescaled reference edge
          if (overrun_flag) begin
            next_seq = TSS_IDLE;
          end else if (presc_tick) begin
            next_seq = TSS_IDLE;
            eos      = 1'b1;
          end
        end
        TSS_SINGLE: begin
          if (overrun_flag) begin
            next_seq = TSS_IDLE;
          end else if (win_cnt == WIN_LAST) begin
            next_seq = TSS_IDLE;
            eos      = 1'b1;
          end
        end
      endcase
    end

    if (eos) begin
      next_snap = next_last_result;
      if (low_leak && auto_scan_enable) begin
        next_wakeup_count_value = next_last_result;
        next_ll_wake = next_last_result > wakeup_threshold;
      end else if (wait_mode || very_low_power_stop) begin
        next_sys_wake = 1'b1;
      end
    end

    // counters load only when the delay has run out
    if (upd_done && !overrun_flag) begin
      next_result_count = snap;
      next_oor_pend     = 1'b1;
    end

    // hardware set wins over a clear in the same cycle
    next_eos_flag = (end_of_scan_flag & ~eos_flag_clear) | eos;
    next_oor_flag = (out_of_range_flag & ~oor_flag_clear)
                    | (oor_pend && (result_count < range_low
                                    || result_count > range_high));
    next_ovr_flag = (overrun_flag & ~overrun_flag_clear) | ovr_event;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      seq                          <= TSS_IDLE;
      presc_cnt                    <= '0;
      period_cnt                   <= PERIOD_RESET;
      win_cnt                      <= '0;
      edge_cnt                     <= COUNT_RESET;
      last_result                  <= COUNT_RESET;
      snap                         <= COUNT_RESET;
      result_count                 <= COUNT_RESET;
      wakeup_count_value           <= COUNT_RESET;
      oor_pend                     <= 1'b0;
      end_of_scan_flag             <= 1'b0;
      out_of_range_flag            <= 1'b0;
      overrun_flag                 <= 1'b0;
      low_leakage_wakeup_interrupt <= 1'b0;
      system_wakeup                <= 1'b0;
    end else begin
      seq                          <= next_seq;
      presc_cnt                    <= next_presc_cnt;
      period_cnt                   <= next_period_cnt;
      win_cnt                      <= next_win_cnt;
      edge_cnt                     <= next_edge_cnt;
      last_result                  <= next_last_result;
      snap                         <= next_snap;
      result_count                 <= next_result_count;
      wakeup_count_value           <= next_wakeup_count_value;
      oor_pend                     <= next_oor_pend;
      end_of_scan_flag             <= next_eos_flag;
      out_of_range_flag            <= next_oor_flag;
      overrun_flag                 <= next_ovr_flag;
      low_leakage_wakeup_interrupt <= next_ll_wake;
      system_wakeup                <= next_sys_wake;
    end
  end

  assign scan_busy        = seq != TSS_IDLE;
  assign end_of_scan_irq  = end_of_scan_flag & eos_irq_enable;
  assign out_of_range_irq = out_of_range_flag & oor_irq_enable;
  assign overrun_irq      = overrun_flag & overrun_irq_enable;
endmodule

// [verif/tss_scan_asserts.sv]
// port-level assertion checker for the touch scan sequencer
`timescale 1ns/1ns
module tss_scan_asserts #(
  parameter int SCAN_CYCLES  = 64,
  parameter int UPDATE_DELAY = 25000
) (
  // clock, reset and controls
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        unit_enable,
  input wire logic        auto_scan_enable,
  input wire logic        software_scan_trigger,
  input wire logic        eos_irq_enable,
  input wire logic        overrun_irq_enable,
  input wire logic        very_low_power_stop,
  input wire logic        wait_mode,
  input wire logic [15:0] wakeup_threshold,
  // results, flags and wakeups
  input wire logic [15:0] result_count,
  input wire logic [15:0] wakeup_count_value,
  input wire logic        end_of_scan_flag,
  input wire logic        out_of_range_flag,
  input wire logic        overrun_flag,
  input wire logic        scan_busy,
  input wire logic        end_of_scan_irq,
  input wire logic        overrun_irq,
  input wire logic        low_leakage_wakeup_interrupt,
  input wire logic        system_wakeup
);
  localparam int EOS_LAT = SCAN_CYCLES + 1;
  logic        eos_d;
  int unsigned since_eos;
  int unsigned next_since_eos;
  logic        trig_ok;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // cycles since the flag rose, saturating so long idle stretches cannot wrap
  always_comb begin
    next_since_eos = (since_eos < 32'hFFFF) ? since_eos + 1 : since_eos;
    if (end_of_scan_flag && !eos_d) begin
      next_since_eos = 0;
    end
  end
  always_ff @(posedge ref_clk) begin
    eos_d     <= sys_rst ? 1'b0 : end_of_scan_flag;
    since_eos <= sys_rst ? 0 : next_since_eos;
  end
  assign trig_ok = software_scan_trigger && unit_enable && !auto_scan_enable && !overrun_flag;
  a_update_delay:
    assert property ($changed(result_count) && unit_enable && $past(unit_enable) |->
      since_eos >= UPDATE_DELAY - 2 && since_eos <= UPDATE_DELAY + 4)
    else $error("result update off its delay");
  a_oor_late:
    assert property ($rose(out_of_range_flag) |-> since_eos >= UPDATE_DELAY - 2)
    else $error("out of range before update");
  a_eos_irq:
    assert property ($rose(end_of_scan_flag) && eos_irq_enable |-> end_of_scan_irq)
    else $error("end of scan irq late");
  a_ovr_irq:
    assert property (overrun_flag && overrun_irq_enable |-> overrun_irq)
    else $error("overrun irq missing");
  a_trig_busy:
    assert property (trig_ok && !scan_busy |=> scan_busy [*8])
    else $error("scan not started");
  a_trig_eos:
    assert property (trig_ok && !scan_busy |->
      ##EOS_LAT ($rose(end_of_scan_flag) || overrun_flag))
    else $error("end of scan latency wrong");
  a_ovr_set:
    assert property (trig_ok && scan_busy |=> overrun_flag)
    else $error("busy trigger not flagged");
  a_ovr_freeze:
    assert property (overrun_flag && $past(overrun_flag) && $past(unit_enable)
      |-> $stable(result_count))
    else $error("counter moved during overrun");
  a_llw_thresh:
    assert property (low_leakage_wakeup_interrupt |-> end_of_scan_flag
      && wakeup_count_value > wakeup_threshold ##1 !low_leakage_wakeup_interrupt)
    else $error("bad low leakage wakeup");
  a_sys_wake:
    assert property (system_wakeup |-> end_of_scan_flag && (wait_mode || very_low_power_stop))
    else $error("bad system wakeup");
endmodule

bind tss_scan_sequencer tss_scan_asserts #(
  .SCAN_CYCLES (SCAN_CYCLES),
  .UPDATE_DELAY(UPDATE_DELAY)
) tss_scan_asserts_i (.*);

// [verif/tb_top.sv]
// self-checking bench for the touch scan sequencer
`timescale 1ns/1ns
module tb_top;
  import tss_pkg::*;
  localparam int SCANS = 64;
  localparam int UD    = 20;
  logic ref_clk, sys_rst, ext_ref_clk_pin, electrode_osc_pin, unit_enable, auto_scan_enable;
  logic scan_clock_source_select, eos_irq_enable, oor_irq_enable, overrun_irq_enable;
  logic software_scan_trigger, eos_flag_clear, oor_flag_clear, overrun_flag_clear;
  logic low_leakage_stop, very_low_leakage_stop, very_low_power_stop, wait_mode;
  logic end_of_scan_flag, out_of_range_flag, overrun_flag, scan_busy, end_of_scan_irq;
  logic out_of_range_irq, overrun_irq, low_leakage_wakeup_interrupt, system_wakeup;
  logic               llw_seen, sys_seen, eos_d, pin_p;
  logic [SCANS-1:0]   rise_hist;
  logic [PSC_W-1:0]   scan_prescaler;
  logic [MOD_W-1:0]   scan_period_modulo;
  logic [COUNT_W-1:0] range_low, range_high, wakeup_threshold, result_count;
  logic [COUNT_W-1:0] wakeup_count_value, snap;
  integer             seed;
  int                 failures, compares, cyc, t0, busy_len, t_eos, exp_cnt;
  int                 lat_q[$];

  tss_scan_sequencer #(.SCAN_CYCLES(SCANS), .UPDATE_DELAY(UD)) tss_scan_sequencer_i (.*);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic check_val(input logic [COUNT_W-1:0] got, input logic [COUNT_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t count got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_lat(input int got, input int exp);
    compares++;
    if (got != exp) begin
      failures++;
      $display("[FAIL] %0t latency got %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  // counters must not move at the flag, so the old value is the note
  task automatic sw_scan;
    snap = result_count;
    // the flag register loads on the edge that closes the last window cycle
    lat_q.push_back(SCANS);
    pulse(software_scan_trigger);
    cyc_n(SCANS + UD + 8);
    check_val(result_count, COUNT_W'(exp_cnt));
  endtask

  // electrode and external pins toggle randomly so every scan counts edges
  always @(negedge ref_clk) begin
    {electrode_osc_pin, ext_ref_clk_pin} <= 2'($random(seed));
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (software_scan_trigger) t0 = cyc;
    // samples taken in reset read as low, as in the pin synchroniser
    rise_hist = {rise_hist[SCANS-2:0], electrode_osc_pin & ~sys_rst & ~pin_p};
    pin_p     = electrode_osc_pin & ~sys_rst;
    // two sync stages: the window's last pair is sampled 62 edges after the trigger
    if (cyc == t0 + SCANS - 2) exp_cnt = $countones(rise_hist);
  end
  always @(negedge ref_clk) begin
    if (end_of_scan_flag && !eos_d && lat_q.size() > 0) begin
      check_lat(cyc - t0, lat_q.pop_front());
      check_val(result_count, snap);
      check_bit(end_of_scan_irq, 1'b1);
    end
    if (end_of_scan_flag && !eos_d && auto_scan_enable && !scan_clock_source_select) begin
      if (t_eos > 0) check_lat(cyc - t_eos, (scan_period_modulo + 1) << scan_prescaler);
      t_eos = cyc;
    end
    if (scan_busy === 1'b1) begin
      busy_len++;
    end else if (busy_len > 0) begin
      if (!overrun_flag && !scan_clock_source_select) begin
        check_lat(busy_len, auto_scan_enable ? 1 << scan_prescaler : SCANS);
      end
      busy_len = 0;
    end
    eos_d = end_of_scan_flag;
    if (low_leakage_wakeup_interrupt) llw_seen = 1'b1;
    if (system_wakeup) sys_seen = 1'b1;
    if (cyc > 10000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    seed = 32'h1BF7;
    sys_rst = 1'b1;
    {unit_enable, auto_scan_enable, scan_clock_source_select, software_scan_trigger} = '0;
    {eos_flag_clear, oor_flag_clear, overrun_flag_clear, eos_d, llw_seen, sys_seen} = '0;
    {low_leakage_stop, very_low_leakage_stop, very_low_power_stop, wait_mode} = '0;
    {eos_irq_enable, oor_irq_enable, overrun_irq_enable} = 3'h7;
    range_low = 16'h0000;
    range_high = 16'h0000;
    wakeup_threshold = 16'h0000;
    scan_prescaler = 3'h7;
    scan_period_modulo = 16'h0001;
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    unit_enable = 1'b1;
    sw_scan();
    check_bit(out_of_range_flag, 1'b1);
    check_bit(out_of_range_irq, 1'b1);
    oor_irq_enable = 1'b0;
    pulse(eos_flag_clear);
    check_bit(out_of_range_irq, 1'b0);
    oor_irq_enable = 1'b1;
    pulse(oor_flag_clear);
    // a second trigger mid-scan is the overrun case
    pulse(software_scan_trigger);
    cyc_n(10);
    pulse(software_scan_trigger);
    cyc_n(2);
    check_bit(overrun_flag, 1'b1);
    check_bit(overrun_irq, 1'b1);
    snap = result_count;
    cyc_n(SCANS + UD + 8);
    check_val(result_count, snap);
    check_bit(end_of_scan_flag, 1'b0);
    unit_enable = 1'b0;
    pulse(overrun_flag_clear);
    unit_enable = 1'b1;
    check_bit(overrun_flag, 1'b0);
    sw_scan();
    // auto bursts: 128-cycle prescaled tick, period of two ticks
    auto_scan_enable = 1'b1;
    for (int m = 0; m < 5; m++) begin
      {low_leakage_stop, very_low_leakage_stop, very_low_power_stop, wait_mode} = 4'h8 >> (m % 4);
      wakeup_threshold = (m == 4) ? 16'hFFFF : 16'h0000;
      // last pass runs from external pin ticks, so its period is irregular
      scan_clock_source_select = (m == 4);
      pulse(eos_flag_clear);
      llw_seen = 1'b0;
      sys_seen = 1'b0;
      for (int i = 0; i < 2000 && end_of_scan_flag !== 1'b1; i++) @(negedge ref_clk);
      cyc_n(UD + 8);
      check_bit(end_of_scan_flag, 1'b1);
      check_bit(llw_seen, m < 2);
      check_bit(sys_seen, m == 2 || m == 3);
      if (m < 2 || m == 4) check_val(wakeup_count_value, result_count);
    end
    auto_scan_enable = 1'b0;
    final_report();
  end
endmodule
